/* File: src/sswd_cfg.svh */
`ifndef SSWD_CFG_SVH
`define SSWD_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and timebase
// ----------------------------------------------------------------------------
`define SSWD_CLK_PERIOD_NS     10
`define SSWD_TICK_PERIOD_NS    1000000
`define SSWD_TICK_CYCLES       (`SSWD_TICK_PERIOD_NS / `SSWD_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Supervisor intervals, counted in timebase ticks
// ----------------------------------------------------------------------------
`define SSWD_WD_TIMEOUT_MS     1600
`define SSWD_WD_TICKS          ((`SSWD_WD_TIMEOUT_MS * 1000000) / `SSWD_TICK_PERIOD_NS)
`define SSWD_RST_TIMEOUT_MS    200
`define SSWD_RST_TICKS         ((`SSWD_RST_TIMEOUT_MS * 1000000) / `SSWD_TICK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Input filters, counted in clock cycles
// ----------------------------------------------------------------------------
`define SSWD_MR_GLITCH_NS      100
`define SSWD_MR_FILTER_CYCLES  (`SSWD_MR_GLITCH_NS / `SSWD_CLK_PERIOD_NS)
`define SSWD_PIN_FILTER_CYCLES 1

`endif

/* File: src/sswd_pkg.sv */
package sswd_pkg;

	typedef enum logic [1:0] {
		SSWD_RUN,
		SSWD_HOLD,
		SSWD_TIMEOUT
	} sswd_state_e;

endpackage : sswd_pkg

/* File: src/sswd_in_filter.sv */
`timescale 1ns/1ps

module sswd_in_filter #(
	parameter int   FILTER_CYCLES = 1,
	parameter logic RESET_VAL     = 1'b1
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level
);
	localparam int CW = $clog2(FILTER_CYCLES + 1);

	logic          s1;
	logic          s2;
	logic          s3;
	logic [CW-1:0] cnt;

	// A change counts only once the second and third stages agree
	wire agree   = (s2 == s3);
	wire differs = agree && (s3 != level);
	wire done    = differs && (cnt == CW'(FILTER_CYCLES - 1));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Pulses shorter than the filter window never reach level
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt   <= '0;
			level <= RESET_VAL;
		end else if (done) begin
			cnt   <= '0;
			level <= s3;
		end else if (differs) begin
			cnt <= cnt + CW'(1);
		end else begin
			cnt <= '0;
		end
	end

	property p_filter_settled;
		@(posedge ref_clk) disable iff (rst)
		$changed(level) |-> ($past(s3) == level) && ($past(s2) == level);
	endproperty
	a_filter_settled: assert property (p_filter_settled)
		else $error("filtered level changed without a settled input");

endmodule : sswd_in_filter

/* File: src/sswd_top.sv */
`timescale 1ns/1ps
`include "sswd_cfg.svh"

module sswd_top #(
	parameter bit HAS_KICK_INPUT = 1'b1,
	parameter int TICK_CYCLES    = `SSWD_TICK_CYCLES,
	parameter int WD_TICKS       = `SSWD_WD_TICKS,
	parameter int RST_TICKS      = `SSWD_RST_TICKS,
	parameter int MR_FILTER      = `SSWD_MR_FILTER_CYCLES
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   supply_good,
	input  wire logic                   manual_reset_n,
	input  wire logic                   reset_n_in,
	output logic                        reset_n_out,
	output logic                        reset_n_oe,
	output logic                        reset_hi_out,
	output logic                        reset_hi_oe,
	input  wire logic                   watchdog_kick,
	input  wire logic                   sda_in,
	input  wire logic                   write_protect,
	input  wire logic                   write_req,
	output logic                        write_permit,
	output sswd_pkg::sswd_state_e       reset_state
);
	import sswd_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES);
	localparam int WW = $clog2(WD_TICKS + 1);
	localparam int RW = $clog2(RST_TICKS + 1);

	// ------------------------------------------------------------------------
	// Pin conditioning
	// ------------------------------------------------------------------------
	logic sup_ok;
	logic mr_lvl;
	logic pin_lvl;
	logic kick_f;
	logic sda_f;
	logic wp_f;

	// Supply starts bad so reset and write blocking hold from power-up
	sswd_in_filter #(.FILTER_CYCLES(`SSWD_PIN_FILTER_CYCLES), .RESET_VAL(1'b0)) u_sup (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (supply_good),
		.level   (sup_ok)
	);
	// Glitch window also absorbs bounce; later bounces only re-arm the hold
	sswd_in_filter #(.FILTER_CYCLES(MR_FILTER), .RESET_VAL(1'b1)) u_mr (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (manual_reset_n),
		.level   (mr_lvl)
	);
	sswd_in_filter #(.FILTER_CYCLES(`SSWD_PIN_FILTER_CYCLES), .RESET_VAL(1'b0)) u_pin (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (reset_n_in),
		.level   (pin_lvl)
	);
	sswd_in_filter #(.FILTER_CYCLES(`SSWD_PIN_FILTER_CYCLES), .RESET_VAL(1'b0)) u_kick (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (watchdog_kick),
		.level   (kick_f)
	);
	sswd_in_filter #(.FILTER_CYCLES(`SSWD_PIN_FILTER_CYCLES), .RESET_VAL(1'b1)) u_sda (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (sda_in),
		.level   (sda_f)
	);
	sswd_in_filter #(.FILTER_CYCLES(`SSWD_PIN_FILTER_CYCLES), .RESET_VAL(1'b0)) u_wp (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (write_protect),
		.level   (wp_f)
	);

	// ------------------------------------------------------------------------
	// Free-running timebase
	// ------------------------------------------------------------------------
	logic [TW-1:0] tick_cnt;
	wire           tick = (tick_cnt == TW'(TICK_CYCLES - 1));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			tick_cnt <= '0;
		else
			tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
	end

	// ------------------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------------------
	logic pin_prev;
	logic kick_prev;
	logic drive;

	wire kick_src  = HAS_KICK_INPUT ? kick_f : sda_f;
	wire kick_edge = (kick_src != kick_prev);
	// Masked while we drive, else our own pull would read as an outside edge
	wire pin_fall  = pin_prev && !pin_lvl && !drive;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_prev  <= 1'b0;
			kick_prev <= HAS_KICK_INPUT ? 1'b0 : 1'b1; // Idle level of the chosen source
		end else begin
			pin_prev  <= pin_lvl;
			kick_prev <= kick_src;
		end
	end

	// ------------------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------------------
	logic [WW-1:0] wd_cnt;
	wire           wd_expire = (wd_cnt == WW'(WD_TICKS));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			wd_cnt <= '0;
		else if (drive || kick_edge)
			wd_cnt <= '0;
		else if (tick && !wd_expire)
			wd_cnt <= wd_cnt + WW'(1);
	end

	// ------------------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------------------
	sswd_state_e   state;
	sswd_state_e   next_state;
	logic [RW-1:0] tim;
	logic [RW-1:0] next_tim;

	wire cause = !sup_ok || !mr_lvl || pin_fall || wd_expire;

	always_comb begin
		next_state = state;
		next_tim   = tim;
		case (state)
			SSWD_RUN: begin
				if (cause)
					next_state = SSWD_HOLD;
			end
			SSWD_HOLD: begin
				// Timeout starts only once every cause has gone away
				if (!cause) begin
					next_state = SSWD_TIMEOUT;
					next_tim   = RW'(RST_TICKS);
				end
			end
			SSWD_TIMEOUT: begin
				if (cause)
					next_state = SSWD_HOLD;
				else if (tim == '0)
					next_state = SSWD_RUN;
				else if (tick)
					next_tim = tim - RW'(1);
			end
			default: next_state = SSWD_HOLD;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= SSWD_HOLD;
			tim   <= RW'(RST_TICKS);
			drive <= 1'b1;
		end else begin
			state <= next_state;
			tim   <= next_tim;
			drive <= (next_state != SSWD_RUN);
		end
	end

	// Open drain: a constant level, only the enables move
	assign reset_n_out  = 1'b0;
	assign reset_hi_out = 1'b1;
	assign reset_n_oe   = drive;
	assign reset_hi_oe  = drive;
	assign reset_state  = state;

	// ------------------------------------------------------------------------
	// Write gating
	// ------------------------------------------------------------------------
	// Floating protect input is pulled low outside, which leaves writes open
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			write_permit <= 1'b0;
		else
			write_permit <= write_req && !wp_f && sup_ok;
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_wd_expire;
		wd_expire |=> drive;
	endproperty
	a_wd_expire: assert property (p_wd_expire)
		else $error("watchdog expiry did not assert reset");

	property p_kick_restart;
		kick_edge && !drive |=> (wd_cnt == '0);
	endproperty
	a_kick_restart: assert property (p_kick_restart)
		else $error("kick edge did not restart watchdog");

	property p_supply_reset;
		!sup_ok |=> drive && !write_permit;
	endproperty
	a_supply_reset: assert property (p_supply_reset)
		else $error("bad supply left reset released or writes open");

	property p_timeout_load;
		state == SSWD_HOLD && !cause |=> state == SSWD_TIMEOUT && tim == RW'(RST_TICKS);
	endproperty
	a_timeout_load: assert property (p_timeout_load)
		else $error("reset timeout not loaded after causes cleared");

	property p_release_after_timeout;
		$fell(drive) |-> $past(state) == SSWD_TIMEOUT && $past(tim) == '0;
	endproperty
	a_release_after_timeout: assert property (p_release_after_timeout)
		else $error("reset released before timeout elapsed");

	property p_outputs_together;
		reset_n_oe == reset_hi_oe && reset_n_oe == (state != SSWD_RUN);
	endproperty
	a_outputs_together: assert property (p_outputs_together)
		else $error("reset outputs disagree");

	property p_pin_fall;
		pin_fall |=> drive ##1 drive;
	endproperty
	a_pin_fall: assert property (p_pin_fall)
		else $error("reset pin falling edge did not start reset");

	property p_mr_hold;
		!mr_lvl |=> drive;
	endproperty
	a_mr_hold: assert property (p_mr_hold)
		else $error("manual reset low did not hold reset");

	property p_wd_cleared;
		drive |=> (wd_cnt == '0);
	endproperty
	a_wd_cleared: assert property (p_wd_cleared)
		else $error("watchdog counted during reset");

	property p_write_protect;
		wp_f |=> !write_permit;
	endproperty
	a_write_protect: assert property (p_write_protect)
		else $error("write permitted while protected");

	property p_write_open;
		write_req && !wp_f && sup_ok |=> write_permit;
	endproperty
	a_write_open: assert property (p_write_open)
		else $error("unprotected write refused");

	c_wd_expire:  cover property (wd_expire);
	c_pin_fall:   cover property (pin_fall);
	c_release:    cover property ($fell(drive));
	c_mr_episode: cover property ($fell(mr_lvl));

endmodule : sswd_top

/* File: tb/sswd_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Supervised host: kicks the watchdog, may pull the reset wire low
// ----------------------------------------------------------------------------
module sswd_host_model (
	input  wire logic       ref_clk,
	input  wire logic       kick_en,
	input  wire logic [7:0] kick_gap,
	input  wire logic       force_low,
	input  wire logic       reset_n_oe,
	output logic            watchdog_kick,
	output logic            reset_n_wire
);
	logic [7:0] cnt;

	initial begin
		watchdog_kick = 1'b0;
		cnt = 8'h00;
	end
	// Pull-up wire: either party pulling low wins
	assign reset_n_wire = ~(reset_n_oe | force_low);
	// Firmware is held in reset, so it only kicks while the wire is high
	always @(posedge ref_clk) begin
		if (kick_en && reset_n_wire) begin
			cnt <= cnt + 8'h01;
			if (cnt >= kick_gap) begin
				cnt <= 8'h00;
				watchdog_kick <= ~watchdog_kick;
			end
		end else begin
			cnt <= 8'h00;
		end
	end
endmodule : sswd_host_model

/* File: tb/sswd_top_tb.sv */
`timescale 1ns/1ps

module sswd_top_tb;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic       supply_good = 1'b0;
	logic       manual_reset_n = 1'b1;
	logic       sda_in = 1'b1;
	logic       write_protect = 1'b0;
	logic       write_req = 1'b0;
	logic       kick_en = 1'b1;
	logic [7:0] kick_gap = 8'h1E;
	logic       force_low = 1'b0;
	logic       reset_n_in;
	logic       watchdog_kick;
	logic       reset_n_oe;
	logic       reset_hi_oe;
	logic       write_permit;
	logic       sda_oe;
	wire        sda_rst_wire = ~sda_oe; // Pull-up wire of the serial-line variant
	int         fails = 0;
	int         tests_run = 0;
	int         n;

	always #5 ref_clk = ~ref_clk;

	sswd_top #(.TICK_CYCLES(4), .WD_TICKS(20), .RST_TICKS(5), .MR_FILTER(10)) DUT (
		.ref_clk(ref_clk), .rst(rst), .supply_good(supply_good),
		.manual_reset_n(manual_reset_n), .reset_n_in(reset_n_in), .reset_n_out(),
		.reset_n_oe(reset_n_oe), .reset_hi_out(), .reset_hi_oe(reset_hi_oe),
		.watchdog_kick(watchdog_kick), .sda_in(sda_in), .write_protect(write_protect),
		.write_req(write_req), .write_permit(write_permit), .reset_state());

	sswd_host_model host (
		.ref_clk(ref_clk), .kick_en(kick_en), .kick_gap(kick_gap),
		.force_low(force_low), .reset_n_oe(reset_n_oe),
		.watchdog_kick(watchdog_kick), .reset_n_wire(reset_n_in));

	// Serial-line variant: its watchdog follows sda_in, its wire has only a pull-up
	sswd_top #(.HAS_KICK_INPUT(1'b0), .TICK_CYCLES(4), .WD_TICKS(20), .RST_TICKS(5),
		.MR_FILTER(10)) DUT_SDA (
		.ref_clk(ref_clk), .rst(rst), .supply_good(supply_good),
		.manual_reset_n(manual_reset_n), .reset_n_in(sda_rst_wire), .reset_n_out(),
		.reset_n_oe(sda_oe), .reset_hi_out(), .reset_hi_oe(),
		.watchdog_kick(watchdog_kick), .sda_in(sda_in), .write_protect(write_protect),
		.write_req(write_req), .write_permit(), .reset_state());

	// ------------------------------------------------------------------------
	// Compare and wait helpers
	// ------------------------------------------------------------------------
	task automatic check(input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: level %b, expected %b", $time, got, exp);
		end
	endtask : check

	task automatic check_in(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			fails++;
			$display("ERROR %0t: %0d cycles, expected %0d..%0d", $time, got, lo, hi);
		end
	endtask : check_in

	task automatic cycles(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask : cycles

	// Waits until drive equals v; both reset outputs must agree then
	task automatic wait_oe(input logic v, input int maxc, output int k);
		k = 0;
		while (reset_n_oe !== v && k < maxc) begin
			cycles(1);
			k++;
		end
		check(reset_n_oe, reset_hi_oe);
	endtask : wait_oe

	task automatic final_report;
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	// Release takes 5 ticks of 4 cycles after the cause clears, plus filter lag
	task automatic power_up;
		@(posedge ref_clk) supply_good <= 1'b1;
		wait_oe(1'b0, 60, n);
		check_in(n, 16, 36);
	endtask : power_up

	task automatic write_gate;
		@(posedge ref_clk) write_req <= 1'b1;
		cycles(2);
		check(1'b1, write_permit);
		@(posedge ref_clk) write_protect <= 1'b1;
		cycles(6);
		check(1'b0, write_permit);
		@(posedge ref_clk) begin
			write_protect <= 1'b0;
			supply_good <= 1'b0;
		end
		cycles(6);
		check(1'b0, write_permit);
		check(1'b1, reset_n_oe);
		power_up();
		check(1'b1, write_permit);
		@(posedge ref_clk) write_req <= 1'b0;
	endtask : write_gate

	task automatic manual;
		@(posedge ref_clk) manual_reset_n <= 1'b0;
		cycles(5);
		@(posedge ref_clk) manual_reset_n <= 1'b1;
		wait_oe(1'b1, 20, n);
		check_in(n, 20, 20);
		@(posedge ref_clk) manual_reset_n <= 1'b0;
		wait_oe(1'b1, 20, n);
		check_in(n, 10, 16);
		cycles(40);
		check(1'b1, reset_n_oe);
		@(posedge ref_clk) manual_reset_n <= 1'b1;
		wait_oe(1'b0, 60, n);
		check_in(n, 20, 40);
	endtask : manual

	task automatic pin_pull;
		// Let the released wire settle high first, or no falling edge can be seen
		cycles(8);
		@(posedge ref_clk) force_low <= 1'b1;
		cycles(3);
		@(posedge ref_clk) force_low <= 1'b0;
		wait_oe(1'b1, 10, n);
		check_in(n, 1, 7);
		wait_oe(1'b0, 60, n);
		check_in(n, 14, 36);
	endtask : pin_pull

	// Serial data toggles every 8 cycles while the kick stops; it must not restart
	task automatic watchdog;
		wait_oe(1'b1, 300, n);
		check_in(n, 300, 300);
		@(posedge ref_clk) kick_gap <= 8'h46;
		wait_oe(1'b1, 300, n);
		check_in(n, 300, 300);
		// Stop right after a kick so the expiry window is known
		@(watchdog_kick);
		@(posedge ref_clk) kick_en <= 1'b0;
		for (n = 0; n < 130 && reset_n_oe !== 1'b1; n++) begin
			@(posedge ref_clk) if (n % 8 == 0) sda_in <= ~sda_in;
			#1;
		end
		check_in(n, 81, 86);
		wait_oe(1'b0, 60, n);
		// Counting starts only at release, so a full timeout follows it
		wait_oe(1'b1, 120, n);
		check_in(n, 77, 82);
	endtask : watchdog

	// Serial-line variant: edges every 8 cycles keep it alive, silence expires it
	task automatic sda_watchdog;
		int hits;
		hits = 0;
		for (n = 0; n < 200; n++) begin
			@(posedge ref_clk) if (n % 8 == 0) sda_in <= ~sda_in;
			#1;
			if (n >= 60 && sda_oe !== 1'b0)
				hits++;
		end
		check_in(hits, 0, 0);
		for (n = 0; n < 120 && sda_oe !== 1'b1; n++)
			cycles(1);
		check_in(n, 74, 79);
	endtask : sda_watchdog

	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		power_up();
		write_gate();
		manual();
		pin_pull();
		watchdog();
		sda_watchdog();
		final_report();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		final_report();
	end
endmodule : sswd_top_tb
